// file: hw/synth_cfg_pkg.sv
// Purpose: constants for the synthesizer output and calibration config bank
// Assumes: 16-bit registers, one per aligned 32-bit APB word
// Notes:   offsets are register indices; byte address is four times the index
package synth_cfg_pkg;
  // register indices and byte addresses
  localparam logic [7:0] gain_drive_idx = 8'h02;
  localparam logic [7:0] route_div_idx  = 8'h03;
  localparam logic [7:0] osc_cal_idx    = 8'h04;
  localparam logic [9:0] gain_drive_addr = {gain_drive_idx, 2'b00};
  localparam logic [9:0] route_div_addr  = {route_div_idx, 2'b00};
  localparam logic [9:0] osc_cal_addr    = {osc_cal_idx, 2'b00};
  // reset values
  localparam logic [15:0] gain_drive_rst = 16'h0f3f;
  localparam logic [15:0] route_div_rst  = 16'h5040;
  localparam logic [15:0] osc_cal_rst    = 16'h0710;
  // gain and drive register fields
  localparam int pump_gain_lsb  = 6;
  localparam int drive_b_lsb    = 3;
  localparam int drive_a_lsb    = 0;
  // routing and divider register fields
  localparam int src_b_lsb      = 14;
  localparam int src_a_lsb      = 12;
  localparam int route_ctl_bit  = 11;
  localparam int phase_detector_delay_lsb    = 5;
  localparam int channel_divider_ratio_lsb      = 0;
  // calibration control register fields
  localparam int osc_ro_bit     = 15;
  localparam int cap_force_bit  = 14;
  localparam int bias_force_bit = 13;
  localparam int core_force_bit = 12;
  localparam int quick_bit      = 11;
  localparam int acal_bit       = 10;
  localparam int fcal_bit       = 9;
  // calibration start defaults when quick resume is off
  localparam logic [7:0] cap_start_rst  = 8'hbf;
  localparam logic [8:0] bias_start_rst = 9'h12c;
  localparam logic [2:0] core_start_rst = 3'h7;
  // phase detector delay: (code + offset) * step oscillator cycles
  localparam logic [8:0] phase_detector_delay_offset = 9'h003;
  localparam int         phase_detector_delay_shift  = 2;
endpackage

// file: hw/synth_cfg_regs.sv
// Purpose: APB register bank for output routing, drive and oscillator calibration
// Assumes: one clock; routing pins are asynchronous and synchronised here
// Notes:   every output comes from a flip-flop, one cycle after its cause, three cycles after a routing pin
//
// Added by the designer: register access over APB.
`timescale 1ns/1ps
`default_nettype none
module synth_cfg_regs
(
  input  wire logic        clock,
  input  wire logic        rstn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // routing pins, asynchronous
  input  wire logic [1:0]  out_a_route_pin,
  input  wire logic [1:0]  out_b_route_pin,
  // calibration results and manual codes, same clock
  input  wire logic [7:0]  cal_capacitor_code,
  input  wire logic [8:0]  cal_bias_current_code,
  input  wire logic [2:0]  cal_core_select,
  input  wire logic [7:0]  osc_capacitor_code,
  input  wire logic [8:0]  osc_bias_current_code,
  input  wire logic [2:0]  osc_core_select,
  // configuration towards the analog side
  output logic      [4:0]  pump_up_gain,
  output logic             pump_gain_valid,
  output logic      [3:0]  out_a_drive_steps,
  output logic      [3:0]  out_b_drive_steps,
  output logic      [1:0]  out_a_source,
  output logic      [1:0]  out_b_source,
  output logic             out_source_invalid,
  output logic             phase_detector_delay_en,
  output logic      [8:0]  phase_detector_delay,
  output logic      [10:0] channel_divider_ratio,
  output logic      [7:0]  osc_capacitor_code_used,
  output logic      [8:0]  osc_bias_current_code_used,
  output logic      [2:0]  osc_core_select_used,
  output logic      [7:0]  cal_start_capacitor_code,
  output logic      [8:0]  cal_start_bias_code,
  output logic      [2:0]  cal_start_core_select,
  output logic             fast_amp_cal_en,
  output logic             fast_freq_cal_en
);

  // register storage
  logic [15:0] gain_reg;          // gain and drive
  logic [15:0] route_reg;         // routing and divider
  logic [15:0] osc_reg;           // calibration control
  // routing pin synchronisers
  logic [1:0]  pin_a_meta_reg;    // first stage, read only by second
  logic [1:0]  pin_a_sync_reg;    // second stage
  logic [1:0]  pin_b_meta_reg;
  logic [1:0]  pin_b_sync_reg;
  // bus decode
  logic        access;            // access phase, first cycle
  logic        commit;            // edge at which the transfer ends
  logic        hit_gain;
  logic        hit_route;
  logic        hit_osc;
  logic [15:0] lane_mask;         // byte strobes widened to bits
  logic [15:0] rd_word;           // register picked for a read
  logic [1:0]  sel_a;             // source chosen before registering
  logic [1:0]  sel_b;

  // merge write data into a register under byte strobes
  function automatic logic [15:0] merge(input logic [15:0] old,
                                        input logic [15:0] data,
                                        input logic [15:0] mask);
    merge = (old & ~mask) | (data & mask);
  endfunction

  // drive code to current in 2.5mA steps, code+1
  function automatic logic [3:0] drive_steps(input logic [2:0] code);
    drive_steps = {1'b0, code} + 4'h1;
  endfunction

  // channel divider code to ratio, zero for not applicable
  function automatic logic [10:0] div_ratio(input logic [4:0] code);
    case (code)
      5'h01: div_ratio = 11'd2;
      5'h02: div_ratio = 11'd4;
      5'h03: div_ratio = 11'd6;
      5'h04: div_ratio = 11'd8;
      5'h05: div_ratio = 11'd12;
      5'h06: div_ratio = 11'd8;
      5'h07: div_ratio = 11'd24;
      5'h08: div_ratio = 11'd32;
      5'h09: div_ratio = 11'd48;
      5'h0a: div_ratio = 11'd64;
      5'h0b: div_ratio = 11'd96;
      5'h0c: div_ratio = 11'd128;
      5'h0d: div_ratio = 11'd192;
      5'h0e: div_ratio = 11'd256;
      5'h0f: div_ratio = 11'd384;
      5'h10: div_ratio = 11'd512;
      5'h11: div_ratio = 11'd768;
      5'h12: div_ratio = 11'd1024;
      5'h13: div_ratio = 11'd1536;
      default: div_ratio = 11'd0;
    endcase
  endfunction

  // phase detector delay in oscillator cycles
  function automatic logic [8:0] dly_cycles(input logic [5:0] code);
    dly_cycles = (code == 6'h00) ? 9'h000
               : ({3'b000, code} + synth_cfg_pkg::phase_detector_delay_offset) << synth_cfg_pkg::phase_detector_delay_shift;
  endfunction

  // bus decode; pready is registered so each access waits one cycle
  always_comb
  begin
    access    = psel && penable && !pready;
    commit    = psel && penable && pready;
    hit_gain  = paddr[11:2] == {2'b00, synth_cfg_pkg::gain_drive_addr[9:2]};
    hit_route = paddr[11:2] == {2'b00, synth_cfg_pkg::route_div_addr[9:2]};
    hit_osc   = paddr[11:2] == {2'b00, synth_cfg_pkg::osc_cal_addr[9:2]};
    lane_mask = {{8{pstrb[1]}}, {8{pstrb[0]}}};
    // unmapped places read as zero
    rd_word   = hit_gain ? gain_reg : hit_route ? route_reg : hit_osc ? osc_reg : 16'h0000;
  end

  // apb answer: one wait cycle, error on unmapped address
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else
    begin
      pready  <= access;
      pslverr <= access && !(hit_gain || hit_route || hit_osc);
      if (access && !pwrite)
      begin
        // upper half reads as zero
        prdata <= {16'h0000, rd_word};
      end
    end
  end

  // gain and drive register, hidden top field stored as written
  // offset and reset
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      gain_reg <= synth_cfg_pkg::gain_drive_rst;
    end
    else if (commit && pwrite && hit_gain)
    begin
      gain_reg <= merge(gain_reg, pwdata[15:0], lane_mask);
    end
  end

  // routing and divider register
  // offset and reset
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      route_reg <= synth_cfg_pkg::route_div_rst;
    end
    else if (commit && pwrite && hit_route)
    begin
      route_reg <= merge(route_reg, pwdata[15:0], lane_mask);
    end
  end

  // calibration control register
  // offset and reset
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      osc_reg <= synth_cfg_pkg::osc_cal_rst;
    end
    else if (commit && pwrite && hit_osc)
    begin
      osc_reg <= merge(osc_reg, pwdata[15:0], lane_mask)
                 & ~(16'h0001 << synth_cfg_pkg::osc_ro_bit);
    end
  end

  // two-flop synchronisers for the routing pins
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      {pin_a_meta_reg, pin_a_sync_reg, pin_b_meta_reg, pin_b_sync_reg} <= 8'h00;
    end
    else
    begin
      pin_a_meta_reg <= out_a_route_pin;
      pin_a_sync_reg <= pin_a_meta_reg;
      pin_b_meta_reg <= out_b_route_pin;
      pin_b_sync_reg <= pin_b_meta_reg;
    end
  end

  // source selection before registering
  always_comb
  begin
    if (route_reg[synth_cfg_pkg::route_ctl_bit])
    begin
      sel_a = route_reg[synth_cfg_pkg::src_a_lsb +: 2];
      sel_b = route_reg[synth_cfg_pkg::src_b_lsb +: 2];
    end
    else
    begin
      sel_a = pin_a_sync_reg;
      sel_b = pin_b_sync_reg;
    end
  end

  // output routing; invalid codes flagged, not corrected
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      out_a_source       <= 2'h1;
      out_b_source       <= 2'h1;
      out_source_invalid <= 1'b0;
    end
    else
    begin
      out_a_source       <= sel_a;
      out_b_source       <= sel_b;
      out_source_invalid <= (sel_a == 2'h3) || (sel_b == 2'h2);
    end
  end

  // gain and drive decode
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      pump_up_gain      <= 5'h1c;
      pump_gain_valid   <= 1'b1;
      out_a_drive_steps <= 4'h8;
      out_b_drive_steps <= 4'h8;
    end
    else
    begin
      pump_up_gain      <= gain_reg[synth_cfg_pkg::pump_gain_lsb +: 5];
      pump_gain_valid   <= gain_reg[synth_cfg_pkg::pump_gain_lsb + 1 +: 4] != 4'h0;
      out_a_drive_steps <= drive_steps(gain_reg[synth_cfg_pkg::drive_a_lsb +: 3]);
      out_b_drive_steps <= drive_steps(gain_reg[synth_cfg_pkg::drive_b_lsb +: 3]);
    end
  end

  // delay and divider decode
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      phase_detector_delay_en <= 1'b1;
      phase_detector_delay    <= 9'h014;
      channel_divider_ratio   <= 11'd0;
    end
    else
    begin
      phase_detector_delay_en <= route_reg[synth_cfg_pkg::phase_detector_delay_lsb +: 6] != 6'h00;
      phase_detector_delay    <= dly_cycles(route_reg[synth_cfg_pkg::phase_detector_delay_lsb +: 6]);
      channel_divider_ratio   <= div_ratio(route_reg[synth_cfg_pkg::channel_divider_ratio_lsb +: 5]);
    end
  end

  // oscillator codes in use: manual when forced, else calibrated
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      osc_capacitor_code_used    <= 8'h00;
      osc_bias_current_code_used <= 9'h000;
      osc_core_select_used       <= 3'h0;
    end
    else
    begin
      osc_capacitor_code_used    <= osc_reg[synth_cfg_pkg::cap_force_bit] ?
                                    osc_capacitor_code : cal_capacitor_code;
      osc_bias_current_code_used <= osc_reg[synth_cfg_pkg::bias_force_bit] ?
                                    osc_bias_current_code : cal_bias_current_code;
      osc_core_select_used       <= osc_reg[synth_cfg_pkg::core_force_bit] ?
                                    osc_core_select : cal_core_select;
    end
  end

  // calibration start point and fast calibration enables
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      cal_start_capacitor_code <= synth_cfg_pkg::cap_start_rst;
      cal_start_bias_code      <= synth_cfg_pkg::bias_start_rst;
      cal_start_core_select    <= synth_cfg_pkg::core_start_rst;
      fast_amp_cal_en          <= 1'b1;
      fast_freq_cal_en         <= 1'b1;
    end
    else
    begin
      // quick resume from held codes, else defaults
      cal_start_capacitor_code <= osc_reg[synth_cfg_pkg::quick_bit] ?
                                  cal_capacitor_code : synth_cfg_pkg::cap_start_rst;
      cal_start_bias_code      <= osc_reg[synth_cfg_pkg::quick_bit] ?
                                  cal_bias_current_code : synth_cfg_pkg::bias_start_rst;
      cal_start_core_select    <= osc_reg[synth_cfg_pkg::quick_bit] ?
                                  cal_core_select : synth_cfg_pkg::core_start_rst;
      fast_amp_cal_en  <= osc_reg[synth_cfg_pkg::acal_bit];
      fast_freq_cal_en <= osc_reg[synth_cfg_pkg::fcal_bit];
    end
  end

  // checks
  chk_osc_top_zero: assert property (@(posedge clock) disable iff (!rstn)
    osc_reg[15] == 1'b0)
    else $error("calibration top bit not zero");
  chk_gain_write: assert property (@(posedge clock) disable iff (!rstn)
    commit && pwrite && hit_gain && pstrb[1:0] == 2'h3 |=> gain_reg == $past(pwdata[15:0]))
    else $error("gain register write lost");
  chk_read_osc: assert property (@(posedge clock) disable iff (!rstn)
    access && !pwrite && hit_osc |=> pready && prdata == {16'h0000, $past(osc_reg)})
    else $error("calibration register read wrong");
  chk_route_pins: assert property (@(posedge clock) disable iff (!rstn)
    !route_reg[11] |=> out_a_source == $past(pin_a_sync_reg) && out_b_source == $past(pin_b_sync_reg))
    else $error("pin routing not followed");
  chk_route_regs: assert property (@(posedge clock) disable iff (!rstn)
    route_reg[11] |=> out_a_source == $past(route_reg[13:12]) && out_b_source == $past(route_reg[15:14]))
    else $error("register routing not followed");
  chk_delay_cycles: assert property (@(posedge clock) disable iff (!rstn)
    route_reg[10:5] == 6'h3f ##1 route_reg[10:5] == 6'h3f |-> phase_detector_delay == 9'd264)
    else $error("delay cycles wrong");
  chk_div_six: assert property (@(posedge clock) disable iff (!rstn)
    route_reg[4:0] == 5'h06 |=> channel_divider_ratio == 11'd8)
    else $error("divider code six wrong");
  chk_cap_force: assert property (@(posedge clock) disable iff (!rstn)
    osc_reg[14] |=> osc_capacitor_code_used == $past(osc_capacitor_code))
    else $error("capcode force ignored");
  chk_bias_force: assert property (@(posedge clock) disable iff (!rstn)
    !osc_reg[13] |=> osc_bias_current_code_used == $past(cal_bias_current_code))
    else $error("calibrated bias not used");
  chk_quick_start: assert property (@(posedge clock) disable iff (!rstn)
    !osc_reg[11] |=> cal_start_core_select == 3'h7 && cal_start_capacitor_code == 8'hbf)
    else $error("default start codes wrong");
  chk_drive_a: assert property (@(posedge clock) disable iff (!rstn)
    gain_reg[2:0] == 3'h7 |=> out_a_drive_steps == 4'h8)
    else $error("drive A steps wrong");

endmodule
`default_nettype wire

// file: test/tb_top.sv
// Purpose: self-checking bench for the synthesizer config register bank
// Assumes: apb slave answers with one wait state; decoded outputs lag one clock
// Notes:   host-side values for hidden fields are always written as required
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin n_errors++; \
  $display("ERROR %0t: mismatch got %h exp %h", $time, got, exp); end end
module tb_top;
  logic        clock;               // 100 MHz system clock
  logic        rstn;                // async reset, active low
  logic        psel;                // apb select
  logic        penable;             // apb access phase
  logic        pwrite;              // apb direction
  logic [11:0] paddr;               // apb byte address
  logic [31:0] pwdata;              // apb write data
  logic [3:0]  pstrb;               // apb byte strobes
  logic [31:0] prdata;              // apb read data
  logic        pready;              // apb completion
  logic        pslverr;             // apb error
  logic [1:0]  pin_a;               // routing pin for output a
  logic [1:0]  pin_b;               // routing pin for output b
  logic [7:0]  cal_cap;             // calibrated capacitor code input
  logic [4:0]  gain;                // decoded pump gain
  logic        gain_ok;             // gain code usable
  logic [3:0]  steps_a;             // drive steps a
  logic [3:0]  steps_b;             // drive steps b
  logic [1:0]  src_a;               // effective source a
  logic [1:0]  src_b;               // effective source b
  logic        src_bad;             // invalid source flag
  logic        dly_en;              // delay enable
  logic [8:0]  dly;                 // delay in oscillator cycles
  logic [10:0] ratio;               // channel divider ratio
  logic [7:0]  cap_used;            // capacitor code in use
  logic [8:0]  bias_used;           // bias code in use
  logic [2:0]  core_used;           // core select in use
  logic [7:0]  cap_start;           // calibration start capacitor
  logic [8:0]  bias_start;          // calibration start bias
  logic [2:0]  core_start;          // calibration start core
  logic        acal_en;             // fast amplitude calibration
  logic        fcal_en;             // fast frequency calibration
  logic [31:0] rd;                  // last read data
  logic        er;                  // last error flag
  int          n_errors;            // mismatches seen
  int          tests_run;           // comparisons made
  // divider ratios per code, codes past 13h give zero
  localparam logic [10:0] div_tab [0:20] = '{11'h000, 11'h002, 11'h004, 11'h006, 11'h008, 11'h00c, 11'h008,
    11'h018, 11'h020, 11'h030, 11'h040, 11'h060, 11'h080, 11'h0c0, 11'h100, 11'h180, 11'h200, 11'h300,
    11'h400, 11'h600, 11'h000};
  // delay codes cycled through: disable, first, last, reset value
  localparam logic [5:0] dly_tab [0:3] = '{6'h00, 6'h01, 6'h3f, 6'h02};

  synth_cfg_regs DUT (.clock(clock), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .out_a_route_pin(pin_a), .out_b_route_pin(pin_b), .cal_capacitor_code(cal_cap),
    .cal_bias_current_code(9'h0a5), .cal_core_select(3'h2), .osc_capacitor_code(8'h81),
    .osc_bias_current_code(9'h1c3), .osc_core_select(3'h5), .pump_up_gain(gain), .pump_gain_valid(gain_ok),
    .out_a_drive_steps(steps_a), .out_b_drive_steps(steps_b), .out_a_source(src_a), .out_b_source(src_b),
    .out_source_invalid(src_bad), .phase_detector_delay_en(dly_en), .phase_detector_delay(dly),
    .channel_divider_ratio(ratio), .osc_capacitor_code_used(cap_used), .osc_bias_current_code_used(bias_used),
    .osc_core_select_used(core_used), .cal_start_capacitor_code(cap_start), .cal_start_bias_code(bias_start),
    .cal_start_core_select(core_start), .fast_amp_cal_en(acal_en), .fast_freq_cal_en(fcal_en));

  // free-running clock
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // one apb transfer; setup starts one edge after entry so release never collides
  task automatic apb(input logic wr, input logic [11:0] a, input logic [15:0] d);
    int n;
    n = 0;
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {16'h0, d};
    @(posedge clock);
    penable <= 1'b1;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (pready !== 1'b1 && n < 40);
    rd = prdata;
    er = pslverr;
    if (n >= 40)
    begin
      n_errors++;
      $display("ERROR %0t: no apb answer", $time);
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // write then let the decoded outputs land
  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    apb(1'b1, a, d);
    repeat (2) @(posedge clock);
  endtask

  // print counts and verdict, then stop
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // hang guard, well beyond the few hundred cycles the tests need
  initial
  begin
    repeat (20000) @(posedge clock);
    n_errors++;
    $display("ERROR %0t: watchdog expired", $time);
    close_out();
  end

  // main sequence
  initial
  begin
    logic [4:0] g;
    logic [2:0] da;
    logic [2:0] db;
    logic [1:0] sa;
    logic [1:0] sb;
    logic [5:0] dc;
    n_errors = 0;
    tests_run = 0;
    rstn = 1'b0;
    {psel, penable, pwrite} = 3'b000;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'hf;
    pin_a = 2'h1;
    pin_b = 2'h1;
    cal_cap = 8'h3c;
    repeat (2) @(posedge clock);
    rstn <= 1'b1;
    // pin-driven sources need two sync stages and the output flop to settle
    repeat (4) @(posedge clock);
    // reset values of outputs and registers
    `CHK(gain, 5'h1c)
    `CHK(gain_ok, 1'b1)
    `CHK({steps_b, steps_a}, 8'h88)
    `CHK({src_b, src_a, src_bad}, 5'b01010)
    `CHK({dly_en, dly}, 10'h214)
    `CHK(ratio, 11'h000)
    `CHK({acal_en, fcal_en}, 2'b11)
    `CHK({cap_start, bias_start, core_start}, {8'hbf, 9'h12c, 3'h7})
    `CHK({cap_used, bias_used, core_used}, {8'h3c, 9'h0a5, 3'h2})
    apb(1'b0, 12'h008, 16'h0); `CHK(rd, 32'h0000_0f3f)
    apb(1'b0, 12'h00c, 16'h0); `CHK(rd, 32'h0000_5040)
    apb(1'b0, 12'h010, 16'h0); `CHK(rd, 32'h0000_0710)
    $display("test reset done");
    // gain and drive fields, both edge codes of gain and drive a, top code of drive b
    for (int i = 0; i < 4; i++)
    begin
      g = (i == 0) ? 5'h04 : (i == 1) ? 5'h00 : (i == 2) ? 5'h01 : 5'h1f;
      da = 3'(i * 5);
      db = 3'(7 - i * 3);
      // top hidden field always carries 1
      wr(12'h008, {5'h01, g, db, da});
      `CHK(gain, g)
      `CHK(gain_ok, g > 5'h01)
      `CHK(steps_a, {1'b0, da} + 4'h1)
      `CHK(steps_b, {1'b0, db} + 4'h1)
      apb(1'b0, 12'h008, 16'h0); `CHK(rd, {16'h0, 5'h01, g, db, da})
    end
    $display("test gain done");
    // register-driven routing with every source code, divider and delay sweep
    for (int i = 0; i < 21; i++)
    begin
      sa = 2'(i);
      sb = 2'(i >> 2);
      dc = dly_tab[i % 4];
      wr(12'h00c, {sb, sa, 1'b1, dc, 5'(i)});
      `CHK({src_b, src_a}, {sb, sa})
      `CHK(src_bad, (sa == 2'h3) || (sb == 2'h2))
      `CHK(dly_en, dc != 6'h00)
      `CHK(dly, (dc == 6'h00) ? 9'h000 : ({3'h0, dc} + 9'h003) * 9'h004)
      `CHK(ratio, div_tab[i])
    end
    // pins take over when the control bit is clear
    wr(12'h00c, 16'h0040);
    pin_a <= 2'h2;
    pin_b <= 2'h3;
    repeat (5) @(posedge clock);
    `CHK({src_b, src_a, src_bad}, 5'b11100)
    pin_a <= 2'h3;
    repeat (5) @(posedge clock);
    `CHK({src_a, src_bad}, 3'b111)
    $display("test routing done");
    // read-only top bit, all overrides and quick resume, fast cal off
    wr(12'h010, 16'hf910);
    apb(1'b0, 12'h010, 16'h0); `CHK(rd, 32'h0000_7910)
    `CHK({cap_used, bias_used, core_used}, {8'h81, 9'h1c3, 3'h5})
    `CHK({cap_start, bias_start, core_start}, {8'h3c, 9'h0a5, 3'h2})
    `CHK({acal_en, fcal_en}, 2'b00)
    // capacitor override alone
    wr(12'h010, 16'h4310);
    `CHK({cap_used, bias_used, core_used}, {8'h81, 9'h0a5, 3'h2})
    `CHK({cap_start, bias_start, core_start}, {8'hbf, 9'h12c, 3'h7})
    `CHK({acal_en, fcal_en}, 2'b01)
    // bias and core overrides
    cal_cap <= 8'h5a;
    wr(12'h010, 16'h3510);
    `CHK({cap_used, bias_used, core_used}, {8'h5a, 9'h1c3, 3'h5})
    `CHK({acal_en, fcal_en}, 2'b10)
    $display("test calibration done");
    // unmapped places answer with an error and change nothing
    apb(1'b0, 12'h014, 16'h0); `CHK({er, rd}, 33'h1_0000_0000)
    apb(1'b0, 12'h000, 16'h0); `CHK({er, rd}, 33'h1_0000_0000)
    apb(1'b1, 12'h004, 16'hffff); `CHK(er, 1'b1)
    apb(1'b0, 12'h008, 16'h0); `CHK({er, rd}, {1'b0, 32'h0000_0ff7})
    $display("test unmapped done");
    close_out();
  end
endmodule
`default_nettype wire
